/* File: core/sel_error_led.sv */
`timescale 1ns/1ps
`include "sel_cfg.svh"
module sel_error_led
  import sel_pkg::*;
#(
  parameter int unsigned NMOD        = 8,
  parameter int unsigned FLICKER_CYC =
    (`SEL_CLK_HZ / `SEL_HZ_PER_MHZ) * `SEL_FLICKER_HALF_US,
  parameter int unsigned FLASH_CYC   =
    (`SEL_CLK_HZ / `SEL_HZ_PER_MHZ) * `SEL_FLASH_STEP_US
) (
  // clock and power-on reset
  input  wire logic                   i_clock,
  input  wire logic                   i_reset_n,
  // apb slave
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire logic                   i_pwrite,
  input  wire logic [`SEL_ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]            i_pwdata,
  output logic      [31:0]            o_prdata,
  output logic                        o_pready,
  output logic                        o_pslverr,
  // diagnosis findings (pins)
  input  wire logic                   i_fault_transient,
  input  wire logic                   i_fault_integrity,
  input  wire logic                   i_fault_proc,
  input  wire logic [NMOD-1:0]        i_fault_sw,
  input  wire logic                   i_error_ack,
  // controller and link status (pins)
  input  wire logic [1:0]             i_safe_net,
  input  wire logic [1:0]             i_io_net,
  input  wire logic                   i_link_up_ok,
  input  wire logic                   i_link_up_act,
  input  wire logic                   i_link_dn_ok,
  input  wire logic                   i_link_dn_act,
  // supply monitors (pins)
  input  wire logic                   i_ctrl_supply_ok,
  input  wire logic                   i_valve_in_range,
  input  wire logic                   i_valve_out_on,
  input  wire logic                   i_valve_overvolt,
  input  wire logic                   i_valve_overcur,
  // state outputs
  output logic                        o_station_halt,
  output logic      [NMOD-1:0]        o_module_halt,
  output logic      [1:0]             o_severity,
  output logic                        o_irq,
  // indicators
  output logic                        o_run_safe_led,
  output logic                        o_run_io_led,
  output logic                        o_link_up_led,
  output logic                        o_link_dn_led,
  output logic                        o_control_supply_indicator,
  output logic                        o_valve_supply_led,
  output logic                        o_diag_led_two,
  output logic                        o_diag_led_three,
  output logic                        o_diag_led_four
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  localparam int unsigned PW = 17 + NMOD;   // synchronised pin count
  logic [1:0] rst_pipe;                     // release stretcher
  wire        rst_n = rst_pipe[1];          // design-wide reset
  // assert at once, release after two edges
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  wire  [PW-1:0] pin_raw = {i_fault_transient, i_fault_integrity, i_fault_proc,
                            i_fault_sw, i_error_ack, i_safe_net, i_io_net,
                            i_link_up_ok, i_link_up_act, i_link_dn_ok,
                            i_link_dn_act, i_ctrl_supply_ok, i_valve_in_range,
                            i_valve_out_on, i_valve_overvolt, i_valve_overcur};
  logic [PW-1:0] pin_s1;                    // metastable stage
  logic [PW-1:0] pin_s2;                    // second stage
  logic [PW-1:0] pin_s3;                    // third stage
  logic [PW-1:0] pin_q;                     // accepted level

  // per bit: a change counts once stages two and three agree
  for (genvar b = 0; b < PW; b++) begin : g_sync
    always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
        pin_s1[b] <= 1'b0;
        pin_s2[b] <= 1'b0;
        pin_s3[b] <= 1'b0;
        pin_q[b]  <= 1'b0;
      end else begin
        pin_s1[b] <= pin_raw[b];
        pin_s2[b] <= pin_s1[b];
        pin_s3[b] <= pin_s2[b];
        if (pin_s2[b] == pin_s3[b]) begin
          pin_q[b] <= pin_s3[b];
        end
      end
    end
  end

  // named views of the accepted levels
  wire            flt_transient = pin_q[16+NMOD];
  wire            flt_integrity = pin_q[15+NMOD];
  wire            flt_proc      = pin_q[14+NMOD];
  wire [NMOD-1:0] flt_sw        = pin_q[13+NMOD:14];
  wire            flt_ack       = pin_q[13];
  wire sel_net_e  safe_net      = sel_net_e'(pin_q[12:11]);
  wire sel_net_e  io_net        = sel_net_e'(pin_q[10:9]);
  wire            up_ok         = pin_q[8];
  wire            up_act        = pin_q[7];
  wire            dn_ok         = pin_q[6];
  wire            dn_act        = pin_q[5];
  wire            us_ok         = pin_q[4];
  wire            vp_range      = pin_q[3];
  wire            vp_out_on     = pin_q[2];
  wire            vp_overvolt   = pin_q[1];
  wire            vp_overcur    = pin_q[0];
  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire acc      = i_psel && i_penable;             // access phase, pready is 1
  wire wr       = acc && i_pwrite;
  wire hit_ctrl = (i_paddr == `SEL_ADDR_CTRL);
  wire hit_st   = (i_paddr == `SEL_ADDR_STATE);
  wire hit_is   = (i_paddr == `SEL_ADDR_IRQ_STAT);
  wire hit_im   = (i_paddr == `SEL_ADDR_IRQ_MASK);
  wire hit_any  = hit_ctrl || hit_st || hit_is || hit_im;
  wire [NMOD-1:0] sw_ack = (wr && hit_ctrl) ? i_pwdata[NMOD-1:0] : '0;
  wire [`SEL_IRQ_W-1:0] is_clr = (wr && hit_is) ? i_pwdata[`SEL_IRQ_W-1:0] : '0;
  assign o_pready  = 1'b1;                         // zero wait states
  assign o_pslverr = acc && !hit_any;              // unmapped address
  // ---------------------------------------------------------------
  // station state machine
  // ---------------------------------------------------------------
  sel_station_e station;                           // station-wide state
  sel_station_e next_station;
  logic         proc_q;                            // processor that reported
  logic [NMOD-1:0] mod_halt;                       // halted modules
  wire  [NMOD-1:0] ack_vec = sw_ack | {NMOD{flt_ack}};
  // fault outranks shutdown; neither returns to run
  always_comb begin
    next_station = station;
    unique case (station)
      SEL_ST_RUN: begin
        if (flt_integrity) begin
          next_station = SEL_ST_FAULT;
        end else if (flt_transient) begin
          next_station = SEL_ST_SHUT;
        end
      end
      SEL_ST_SHUT: begin                           // only reset or escalation leaves
        if (flt_integrity) begin
          next_station = SEL_ST_FAULT;             // escalation
        end
      end
      SEL_ST_FAULT: next_station = SEL_ST_FAULT;   // no way out
      default:      next_station = SEL_ST_FAULT;   // corrupt code is unsafe
    endcase
  end

  // state register, reset is the sole way back to run
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      station <= SEL_ST_RUN;
      proc_q  <= 1'b0;
    end else begin
      station <= next_station;
      if (next_station != station) begin
        proc_q <= flt_proc;                        // remember reporter
      end
    end
  end

  // module halts: set wins over acknowledge
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      mod_halt <= '0;
    end else begin
      mod_halt <= (mod_halt & ~ack_vec) | flt_sw;
    end
  end
  // severity, most serious state shown
  wire sel_sev_e sev = (station == SEL_ST_FAULT) ? SEL_SEV_FAULT :
                       (station == SEL_ST_SHUT)  ? SEL_SEV_SHUT  :
                       (|mod_halt)               ? SEL_SEV_MODULE : SEL_SEV_NONE;

  assign o_station_halt = (station != SEL_ST_RUN);
  assign o_module_halt  = mod_halt;
  assign o_severity     = sev;
  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  logic [`SEL_IRQ_W-1:0] irq_stat;                 // sticky events
  logic [`SEL_IRQ_W-1:0] irq_mask;                 // enables
  logic                  us_ok_d;                  // previous supply level
  wire  [`SEL_IRQ_W-1:0] irq_set;
  assign irq_set[`SEL_IRQ_SHUT]   = (next_station == SEL_ST_SHUT) &&
                                    (station != SEL_ST_SHUT);
  assign irq_set[`SEL_IRQ_FAULT]  = (next_station == SEL_ST_FAULT) &&
                                    (station != SEL_ST_FAULT);
  assign irq_set[`SEL_IRQ_MODULE] = |(flt_sw & ~mod_halt);
  assign irq_set[`SEL_IRQ_SUPPLY] = us_ok_d && !us_ok;

  // write one clears; a same-cycle event keeps the bit set
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= '0;
      irq_mask <= `SEL_IRQ_MASK_RST;
      us_ok_d  <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~is_clr) | irq_set;
      us_ok_d  <= us_ok;
      if (wr && hit_im) begin
        irq_mask <= i_pwdata[`SEL_IRQ_W-1:0];
      end
    end
  end

  assign o_irq = |(irq_stat & irq_mask);
  // read mux, unused bits read zero
  logic [31:0] rd_state;
  always_comb begin
    rd_state = '0;
    rd_state[NMOD-1:0] = mod_halt;
    rd_state[`SEL_ST_STATION_LSB +: 3] = station;
    rd_state[`SEL_ST_SEV_LSB +: 2]     = sev;
    rd_state[`SEL_ST_PROC_BIT]         = proc_q;
  end
  assign o_prdata = !acc || i_pwrite ? 32'h0 :
                    hit_st ? rd_state :
                    hit_is ? {{(32-`SEL_IRQ_W){1'b0}}, irq_stat} :
                    hit_im ? {{(32-`SEL_IRQ_W){1'b0}}, irq_mask} : 32'h0;
  // ---------------------------------------------------------------
  // blink dividers
  // ---------------------------------------------------------------
  logic [31:0] flk_cnt;                            // flicker divider
  logic [31:0] fls_cnt;                            // flash step divider
  logic        flicker;                            // fast square wave
  logic [2:0]  phase;                              // flash step phase

  // flicker toggles each half period, flash advances per step
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      flk_cnt <= '0;
      fls_cnt <= '0;
      flicker <= 1'b0;
      phase   <= '0;
    end else begin
      if (flk_cnt == FLICKER_CYC - 1) begin
        flk_cnt <= '0;
        flicker <= !flicker;
      end else begin
        flk_cnt <= flk_cnt + 32'h1;
      end
      if (fls_cnt == FLASH_CYC - 1) begin
        fls_cnt <= '0;
        phase   <= phase + 3'h1;
      end else begin
        fls_cnt <= fls_cnt + 32'h1;
      end
    end
  end

  wire flash  = phase[0];                          // regular slow flash
  wire single = (phase == 3'h0);                   // flash then break
  wire dbl    = single || (phase == `SEL_FLASH_DBL_PHASE);
  // ---------------------------------------------------------------
  // indicator encoding
  // ---------------------------------------------------------------
  function automatic logic run_led(input sel_net_e n, input logic fk,
                                   input logic fs);
    unique case (n)
      SEL_NET_OP:     run_led = 1'b1;
      SEL_NET_PREOP:  run_led = fk;
      SEL_NET_SAFEOP: run_led = fs;
      SEL_NET_INIT:   run_led = 1'b0;
    endcase
  endfunction

  wire next_run_safe = run_led(safe_net, flicker, flash);
  wire next_run_io   = run_led(io_net, flicker, flash);
  wire next_link_up  = up_ok && (up_act ? flash : 1'b1);
  wire next_link_dn  = dn_ok && (dn_act ? flash : 1'b1);
  // overcurrent outranks overvoltage, no supply stays dark
  wire next_valve    = vp_overcur  ? dbl :
                       vp_overvolt ? single :
                       vp_range    ? (vp_out_on ? 1'b1 : flicker) : 1'b0;
  wire st_down       = (station != SEL_ST_RUN);
  // shutdown lights two, fault darkens it
  wire next_diag_led_two    = (station == SEL_ST_SHUT) ? 1'b1 :
                       (station == SEL_ST_FAULT) ? 1'b0 : ((|mod_halt) && flicker);
  wire next_diag_led_three    = st_down && !proc_q;
  wire next_diag_led_four    = st_down && proc_q;

  // led flops keep outputs glitch free
  logic [8:0] led_q;                               // registered indicators
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      led_q <= '0;
    end else begin
      led_q <= {next_run_safe, next_run_io, next_link_up, next_link_dn,
                us_ok, next_valve, next_diag_led_two, next_diag_led_three, next_diag_led_four};
    end
  end
  assign {o_run_safe_led, o_run_io_led, o_link_up_led, o_link_dn_led,
          o_control_supply_indicator, o_valve_supply_led, o_diag_led_two,
          o_diag_led_three, o_diag_led_four} = led_q;
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!rst_n);

  sequence s_transient_in_run;
    (station == SEL_ST_RUN) && flt_transient && !flt_integrity;
  endsequence
  sequence s_ack_clear;
    ack_vec[0] && !flt_sw[0] && mod_halt[0];
  endsequence
  AST_SHUT_ENTER: assert property (s_transient_in_run |=> station == SEL_ST_SHUT)
    else $error("transient fault did not enter shutdown");
  AST_SHUT_HOLD: assert property ((station == SEL_ST_SHUT)
    |=> (station == SEL_ST_SHUT || station == SEL_ST_FAULT))
    else $error("shutdown left without reset");
  AST_FAULT_HOLD: assert property ((station == SEL_ST_FAULT)
    |=> (station == SEL_ST_FAULT)[*8])
    else $error("station fault did not hold");
  AST_MOD_SET: assert property (flt_sw[0] && !flt_transient && !flt_integrity
    && (station == SEL_ST_RUN) |=> mod_halt[0] && !o_station_halt)
    else $error("software fault did not halt module");
  AST_MOD_ACK: assert property (s_ack_clear |=> !mod_halt[0])
    else $error("acknowledge did not clear module");
  AST_RUN_SAFE: assert property ((safe_net == SEL_NET_OP) |=> o_run_safe_led)
    else $error("safety run led not steady in operational");
  AST_RUN_IO: assert property ((io_net == SEL_NET_INIT) |=> !o_run_io_led)
    else $error("io run led lit in init");
  AST_LINK_UP: assert property (up_ok && !up_act |=> o_link_up_led)
    else $error("upstream link led not steady");
  AST_US_LED: assert property (us_ok |-> ##1 o_control_supply_indicator == $past(us_ok))
    else $error("control supply led wrong");
  AST_DIAG_FAULT: assert property ((station == SEL_ST_FAULT)
    ##1 (station == SEL_ST_FAULT) |-> !o_diag_led_two && (o_diag_led_three != o_diag_led_four))
    else $error("fault diag leds wrong");
  AST_SEV: assert property (flt_integrity |=> o_severity == SEL_SEV_FAULT)
    else $error("severity not fault after integrity error");

endmodule

/* File: core/sel_cfg.svh */
`ifndef SEL_CFG_SVH
`define SEL_CFG_SVH
// ---------------------------------------------------------------
// clock and indicator timing
// ---------------------------------------------------------------
`define SEL_CLK_HZ          40000000
`define SEL_HZ_PER_MHZ      1000000
`define SEL_FLICKER_HALF_US 50000
`define SEL_FLASH_STEP_US   200000
// ---------------------------------------------------------------
// register map (byte addresses) and fields
// ---------------------------------------------------------------
`define SEL_ADDR_W          8
`define SEL_ADDR_CTRL       8'h00
`define SEL_ADDR_STATE      8'h04
`define SEL_ADDR_IRQ_STAT   8'h08
`define SEL_ADDR_IRQ_MASK   8'h0C
`define SEL_ST_STATION_LSB  16
`define SEL_ST_SEV_LSB      20
`define SEL_ST_PROC_BIT     24
`define SEL_IRQ_W           4
`define SEL_IRQ_SHUT        0
`define SEL_IRQ_FAULT       1
`define SEL_IRQ_MODULE      2
`define SEL_IRQ_SUPPLY      3
`define SEL_IRQ_MASK_RST    4'h0
`define SEL_FLASH_DBL_PHASE 3'h2
`endif

/* File: core/sel_pkg.sv */
package sel_pkg;
  // station-wide error state, one-hot
  typedef enum logic [2:0] {
    SEL_ST_RUN   = 3'b001,
    SEL_ST_SHUT  = 3'b010,
    SEL_ST_FAULT = 3'b100
  } sel_station_e;
  // network state of a communication controller
  typedef enum logic [1:0] {
    SEL_NET_INIT   = 2'h0,
    SEL_NET_PREOP  = 2'h1,
    SEL_NET_SAFEOP = 2'h2,
    SEL_NET_OP     = 2'h3
  } sel_net_e;
  // reported severity, highest wins
  typedef enum logic [1:0] {
    SEL_SEV_NONE   = 2'h0,
    SEL_SEV_MODULE = 2'h1,
    SEL_SEV_SHUT   = 2'h2,
    SEL_SEV_FAULT  = 2'h3
  } sel_sev_e;
endpackage

/* File: testbench/sel_far_side.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// far side: controllers, supply monitors, operator
// ---------------------------------------------------------------
module sel_far_side (
  // clock
  input  wire logic       i_clock,
  // diagnosis pins
  output logic            o_fault_transient, o_fault_integrity, o_fault_proc,
  output logic      [7:0] o_fault_sw,
  output logic            o_error_ack,
  // controller and link pins
  output logic      [1:0] o_safe_net, o_io_net,
  output logic            o_link_up_ok, o_link_up_act, o_link_dn_ok, o_link_dn_act,
  // supply pins
  output logic            o_ctrl_supply_ok, o_valve_in_range, o_valve_out_on,
  output logic            o_valve_overvolt, o_valve_overcur
);
  // levels only; every pin holds a defined value from time zero
  initial begin
    {o_fault_transient, o_fault_integrity, o_fault_proc, o_fault_sw} = '0;
    {o_error_ack, o_safe_net, o_io_net} = '0;
    {o_link_up_ok, o_link_up_act, o_link_dn_ok, o_link_dn_act} = '0;
    {o_valve_in_range, o_valve_out_on, o_valve_overvolt, o_valve_overcur} = '0;
    o_ctrl_supply_ok = 1'b1;
  end
  // diagnosis findings, changed just after an edge
  task automatic set_faults(input logic tr, ig, pr, input logic [7:0] sw);
    @(posedge i_clock);
    {o_fault_transient, o_fault_integrity, o_fault_proc, o_fault_sw} <= {tr, ig, pr, sw};
  endtask
  task automatic set_net(input logic [1:0] sn, io);
    @(posedge i_clock);
    {o_safe_net, o_io_net} <= {sn, io};
  endtask
  task automatic set_link(input logic uo, ua, dok, da);
    @(posedge i_clock);
    {o_link_up_ok, o_link_up_act, o_link_dn_ok, o_link_dn_act} <= {uo, ua, dok, da};
  endtask
  task automatic set_supply(input logic cs, input logic [3:0] v);
    @(posedge i_clock);
    o_ctrl_supply_ok <= cs;
    {o_valve_in_range, o_valve_out_on, o_valve_overvolt, o_valve_overcur} <= v;
  endtask
  // operator acknowledge, held long enough to pass the pin filter
  task automatic ack();
    @(posedge i_clock);
    o_error_ack <= 1'b1;
    repeat (6) @(posedge i_clock);
    o_error_ack <= 1'b0;
  endtask
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`include "sel_cfg.svh"
module tb;
  import sel_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam logic [31:0] P_OFF = 0, P_ON = 1, P_FLK = 2, P_FLS = 3, P_DBL = 4, P_SGL = 5;
  localparam int L_SAFE = 8, L_IO = 7, L_UP = 6, L_DN = 5, L_CS = 4, L_VALVE = 3;
  logic i_clock = 1'b0, i_reset_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, rd;
  logic er;
  int n_errors = 0, n_compared = 0, cycles = 0;
  wire logic [31:0] o_prdata;
  wire logic [7:0] o_module_halt, i_fault_sw;
  wire logic [1:0] o_severity, i_safe_net, i_io_net;
  wire logic o_pready, o_pslverr, o_station_halt, o_irq, o_run_safe_led, o_run_io_led;
  wire logic o_link_up_led, o_link_dn_led, o_control_supply_indicator, o_valve_supply_led;
  wire logic o_diag_led_two, o_diag_led_three, o_diag_led_four;
  wire logic i_fault_transient, i_fault_integrity, i_fault_proc, i_error_ack;
  wire logic i_link_up_ok, i_link_up_act, i_link_dn_ok, i_link_dn_act, i_ctrl_supply_ok;
  wire logic i_valve_in_range, i_valve_out_on, i_valve_overvolt, i_valve_overcur;
  // all indicators in one vector for the pattern meter
  wire logic [8:0] leds = {o_run_safe_led, o_run_io_led, o_link_up_led, o_link_dn_led,
    o_control_supply_indicator, o_valve_supply_led, o_diag_led_two, o_diag_led_three,
    o_diag_led_four};
  // short divider counts keep pattern windows brief
  sel_error_led #(.NMOD(8), .FLICKER_CYC(4), .FLASH_CYC(8)) i_dut (
    .i_clock, .i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
    .o_pready, .o_pslverr, .i_fault_transient, .i_fault_integrity, .i_fault_proc,
    .i_fault_sw, .i_error_ack, .i_safe_net, .i_io_net, .i_link_up_ok, .i_link_up_act,
    .i_link_dn_ok, .i_link_dn_act, .i_ctrl_supply_ok, .i_valve_in_range, .i_valve_out_on,
    .i_valve_overvolt, .i_valve_overcur, .o_station_halt, .o_module_halt, .o_severity,
    .o_irq, .o_run_safe_led, .o_run_io_led, .o_link_up_led, .o_link_dn_led,
    .o_control_supply_indicator, .o_valve_supply_led, .o_diag_led_two, .o_diag_led_three,
    .o_diag_led_four);
  sel_far_side far (
    .i_clock, .o_fault_transient(i_fault_transient), .o_fault_integrity(i_fault_integrity),
    .o_fault_proc(i_fault_proc), .o_fault_sw(i_fault_sw), .o_error_ack(i_error_ack),
    .o_safe_net(i_safe_net), .o_io_net(i_io_net), .o_link_up_ok(i_link_up_ok),
    .o_link_up_act(i_link_up_act), .o_link_dn_ok(i_link_dn_ok),
    .o_link_dn_act(i_link_dn_act), .o_ctrl_supply_ok(i_ctrl_supply_ok),
    .o_valve_in_range(i_valve_in_range), .o_valve_out_on(i_valve_out_on),
    .o_valve_overvolt(i_valve_overvolt), .o_valve_overcur(i_valve_overcur));
  // ---------------------------------------------------------------
  // clock, watchdog, helpers
  // ---------------------------------------------------------------
  always #12.5 i_clock = ~i_clock;
  // hang guard, far above the expected run length
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("[FAIL] watchdog cycles expected below %0d seen %0d", 20000, cycles);
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic do_reset(input int n);
    @(posedge i_clock);
    i_reset_n <= 1'b0;
    repeat (n) @(posedge i_clock);
    i_reset_n <= 1'b1;
    repeat (4) @(posedge i_clock);
  endtask
  // pin path needs six edges; twelve leaves margin
  task automatic settle();
    repeat (12) @(posedge i_clock);
    #1;
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge i_clock);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {1'b1, 1'b0, wr, a, wd};
    @(posedge i_clock);
    i_penable <= 1'b1;
    @(posedge i_clock);
    while (o_pready !== 1'b1) begin
      @(posedge i_clock);
    end
    rd = o_prdata;
    er = o_pslverr;
    {i_psel, i_penable} <= 2'b00;
  endtask
  // classify an indicator by toggles over 128 cycles
  task automatic pattern(input int idx, output logic [31:0] code);
    int hi, tg;
    logic prev, bad;
    {hi, tg, bad, prev} = {32'd0, 32'd0, 1'b0, leds[idx]};
    repeat (128) begin
      @(posedge i_clock);
      #1;
      bad |= $isunknown(leds[idx]);
      tg += (leds[idx] !== prev);
      hi += (leds[idx] === 1'b1);
      prev = leds[idx];
    end
    if (bad) code = 32'hFF;
    else if (tg == 0) code = (hi == 128) ? P_ON : P_OFF;
    else code = (tg >= 24) ? P_FLK : (tg >= 12) ? P_FLS : (tg >= 6) ? P_DBL : P_SGL;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_run_leds();
    logic [31:0] c;
    logic [31:0] tab [4];
    tab = '{P_OFF, P_FLK, P_FLS, P_ON};
    for (int s = 0; s < 4; s++) begin
      far.set_net(2'(s), 2'(3 - s));
      settle();
      pattern(L_SAFE, c);
      chk("safe run led", tab[s], c);
      pattern(L_IO, c);
      chk("io run led", tab[3 - s], c);
    end
  endtask
  task automatic t_links();
    logic [31:0] c;
    logic [31:0] tab [3];
    tab = '{P_OFF, P_ON, P_FLS};
    for (int k = 0; k < 3; k++) begin
      far.set_link(k > 0, k == 2, k < 2, k == 0);
      settle();
      pattern(L_UP, c);
      chk("upstream led", tab[k], c);
      pattern(L_DN, c);
      chk("downstream led", tab[2 - k], c);
    end
  endtask
  task automatic t_supply();
    logic [31:0] c;
    logic [31:0] tab [5];
    logic [3:0] vc [5];
    tab = '{P_ON, P_FLK, P_SGL, P_DBL, P_OFF};
    vc = '{4'b1100, 4'b1000, 4'b0010, 4'b1111, 4'b0000};
    for (int k = 0; k < 5; k++) begin
      far.set_supply(1'b1, vc[k]);
      settle();
      pattern(L_VALVE, c);
      chk("valve led", tab[k], c);
    end
    chk("ctrl supply led on", 32'(1'b1), 32'(leds[L_CS]));
    apb(1'b0, `SEL_ADDR_IRQ_MASK, 32'h0);
    chk("mask reset value", 32'h0, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped error", 32'(1'b1), 32'(er));
    chk("unmapped data", 32'h0, rd);
    far.set_supply(1'b0, 4'b0000);
    settle();
    chk("ctrl supply led off", 32'h0, 32'(leds[L_CS]));
    chk("irq while masked", 32'h0, 32'(o_irq));
    apb(1'b0, `SEL_ADDR_IRQ_STAT, 32'h0);
    chk("irq status", 32'h8, rd);
    apb(1'b1, `SEL_ADDR_IRQ_MASK, 32'h8);
    repeat (2) @(posedge i_clock);
    chk("irq unmasked", 32'h1, 32'(o_irq));
    apb(1'b1, `SEL_ADDR_IRQ_STAT, 32'h8);
    repeat (2) @(posedge i_clock);
    chk("irq cleared", 32'h0, 32'(o_irq));
    far.set_supply(1'b1, 4'b1100);
    settle();
  endtask
  task automatic t_module();
    far.set_faults(1'b0, 1'b0, 1'b0, 8'h29);
    settle();
    chk("module halt", 32'h29, 32'(o_module_halt));
    chk("station keeps running", 32'h0, 32'(o_station_halt));
    chk("severity module", 32'(SEL_SEV_MODULE), 32'(o_severity));
    far.ack();
    settle();
    chk("ack refused under fault", 32'h29, 32'(o_module_halt));
    far.set_faults(1'b0, 1'b0, 1'b0, 8'h00);
    settle();
    chk("halt held without ack", 32'h29, 32'(o_module_halt));
    apb(1'b1, `SEL_ADDR_CTRL, 32'h20);
    repeat (3) @(posedge i_clock);
    chk("register ack one module", 32'h09, 32'(o_module_halt));
    far.ack();
    settle();
    chk("pin ack clears", 32'h00, 32'(o_module_halt));
    chk("severity none", 32'(SEL_SEV_NONE), 32'(o_severity));
  endtask
  task automatic t_station();
    far.set_faults(1'b1, 1'b0, 1'b1, 8'h00);
    settle();
    chk("shutdown halt", 32'h1, 32'(o_station_halt));
    chk("diag shutdown second", 32'h5, 32'(leds[2:0]));
    apb(1'b0, `SEL_ADDR_STATE, 32'h0);
    chk("state shutdown", 32'h2, 32'(rd[18:16]));
    far.set_faults(1'b0, 1'b0, 1'b1, 8'h00);
    far.ack();
    apb(1'b1, `SEL_ADDR_CTRL, 32'hFF);
    settle();
    chk("shutdown holds", 32'(SEL_SEV_SHUT), 32'(o_severity));
    far.set_faults(1'b0, 1'b1, 1'b1, 8'h01);
    settle();
    chk("escalate to fault", 32'(SEL_SEV_FAULT), 32'(o_severity));
    chk("diag fault second", 32'h1, 32'(leds[2:0]));
    far.set_faults(1'b0, 1'b0, 1'b1, 8'h00);
    far.ack();
    settle();
    chk("fault holds", 32'(SEL_SEV_FAULT), 32'(o_severity));
    do_reset(4);
    #1;
    chk("reset restarts", 32'h0, 32'(o_station_halt));
    far.set_faults(1'b0, 1'b1, 1'b0, 8'h00);
    settle();
    chk("fault halt", 32'h1, 32'(o_station_halt));
    chk("diag fault first", 32'h2, 32'(leds[2:0]));
    far.set_faults(1'b0, 1'b0, 1'b0, 8'h00);
    do_reset(4);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    do_reset(20);
    t_run_leds();
    t_links();
    t_supply();
    t_module();
    t_station();
    print_verdict();
  end
endmodule
